// File: srma_pkg.sv
// Constants and types for the SPI register bank
`default_nettype none
package srma_pkg;
    localparam int CTRL_N = 19;
    localparam int STAT_N = 10;
    localparam int FRAME_BITS = 16;
    localparam int MODE_BIT = 7;
    localparam int DATA_LSB = 8;
    localparam int MSC_IDX = 0;
    localparam int HW_IDX = 1;
    localparam logic [4:0] BIT_CNT_LAST = 5'h0F;
    localparam logic [4:0] BIT_CNT_FULL = 5'h10;

    typedef logic [CTRL_N-1:0][7:0] srma_ctrl_t;
    typedef logic [STAT_N-1:0][7:0] srma_stat_t;

    // Control addresses, index 0 on the right
    localparam logic [CTRL_N-1:0][6:0] CTRL_ADDR = {
        7'h1E, 7'h1C, 7'h19, 7'h18, 7'h17, 7'h15, 7'h14, 7'h10, 7'h0D, 7'h0C,
        7'h09, 7'h08, 7'h07, 7'h06, 7'h05, 7'h04, 7'h03, 7'h02, 7'h01};
    // Implemented (non-reserved) bits
    localparam srma_ctrl_t CTRL_MASK = {
        8'hFF, 8'h05, 8'hFF, 8'hFF, 8'hFF, 8'h77, 8'h77, 8'h70, 8'h77, 8'h77,
        8'h3F, 8'h3F, 8'hA7, 8'hC4, 8'h23, 8'hFB, 8'hF7, 8'hFB, 8'hFF};
    // Bits the device hardware may also update
    localparam srma_ctrl_t CTRL_HWMASK = {{(CTRL_N-2){8'h00}}, 8'h20, 8'hFC};
    localparam srma_ctrl_t CTRL_POR = {CTRL_N{8'h00}};
    localparam srma_ctrl_t CTRL_RESTART = {CTRL_N{8'h00}};
    // Bits that keep their value on restart
    localparam srma_ctrl_t CTRL_KEEP = {{(CTRL_N-2){8'hFF}}, 8'hD9, 8'h23};
    // Strap-dependent bits of the hardware configuration register
    localparam logic [7:0] HARDWARE_CONFIG_CONTROL_Y_MASK = 8'h88;

    localparam logic [STAT_N-1:0][6:0] STAT_ADDR = {
        7'h55, 7'h54, 7'h47, 7'h46, 7'h45, 7'h44, 7'h43, 7'h42, 7'h41, 7'h40};
    localparam srma_stat_t STAT_MASK = {
        8'h0F, 8'h0F, 8'h30, 8'hF7, 8'h06, 8'h67, 8'hCF, 8'h07, 8'hFF, 8'h5F};
    localparam srma_stat_t STAT_POR = {STAT_N{8'h00}};

    localparam logic [6:0] WAKE_ADDR = 7'h48;
    localparam logic [7:0] WAKE_MASK = 8'hF7;
    localparam logic [6:0] IDENT_ADDR = 7'h7E;
    localparam logic [15:0] RESP_POR = 16'h0000;
endpackage
`default_nettype wire

// File: srma_spi_regs.sv
// SPI slave and register bank with control, status, level and ident registers
// Behaviour
// - Frame is 16 bits: address, mode, data
// - Mode bit zero only reads the register
// - Mode bit one writes the data byte
// - Address in bits 0-6, data in 8-15
// - Power-on and soft reset load defaults
// - Restart loads restart values, keeps marked bits
// - Bits are read-only, host, or host+hardware
// - Reserved bits read zero, host writes zero
// - Only host or hardware-kind bits change control
// - One frame addresses at most one register
// - Control range read or written by mode
// - Status write access clears clearable bits
// - Level and ident registers never clear
// - Written value shows in a later frame
`timescale 1ns/1ps
`default_nettype none
module srma_spi_regs #(
    // Arbitrary neutral identifier value
    parameter logic [7:0] FAMILY_PRODUCT_ID = 8'hA5,
    parameter logic [7:0] HARDWARE_CONFIG_CONTROL_POR_Y = 8'h00
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // SPI link
    input wire logic spi_sclk_i,
    input wire logic spi_csn_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    // Device events
    input wire logic soft_reset_i,
    input wire logic restart_i,
    input wire logic [srma_pkg::CTRL_N-1:0] ctrl_hw_we_i,
    input wire srma_pkg::srma_ctrl_t ctrl_hw_data_i,
    input wire srma_pkg::srma_stat_t status_set_i,
    input wire logic [7:0] wake_level_i,
    // Register contents
    output srma_pkg::srma_ctrl_t ctrl_o,
    output srma_pkg::srma_stat_t status_o,
    output logic access_done_o
);

    localparam srma_pkg::srma_ctrl_t POR_VAL = srma_pkg::CTRL_POR |
        {{(srma_pkg::CTRL_N-2){8'h00}}, HARDWARE_CONFIG_CONTROL_POR_Y & srma_pkg::HARDWARE_CONFIG_CONTROL_Y_MASK, 8'h00};

    // Link side: sampled on falling, driven on rising edge
    logic link_rst;
    logic [4:0] bit_cnt;
    logic [15:0] frame_word;
    logic frame_ok;
    logic [15:0] resp_word;

    assign link_rst = rst_i | spi_csn_i;

    always_ff @(negedge spi_sclk_i or posedge link_rst)
    begin
        if (link_rst)
            bit_cnt <= 5'h00;
        else if (bit_cnt != srma_pkg::BIT_CNT_FULL)
            bit_cnt <= bit_cnt + 5'h01;
    end

    always_ff @(negedge spi_sclk_i or posedge rst_i)
    begin
        if (rst_i)
            frame_word <= 16'h0000;
        else if (bit_cnt != srma_pkg::BIT_CNT_FULL)
            frame_word[bit_cnt[3:0]] <= spi_mosi_i;
    end

    always_ff @(negedge spi_sclk_i or posedge rst_i)
    begin
        if (rst_i)
            frame_ok <= 1'b0;
        else
            frame_ok <= (bit_cnt == srma_pkg::BIT_CNT_LAST);
    end

    always_ff @(posedge spi_sclk_i or posedge link_rst)
    begin
        if (link_rst)
        begin
            spi_miso_o <= 1'b0;
            spi_miso_oe_o <= 1'b0;
        end
        else
        begin
            spi_miso_o <= (bit_cnt != srma_pkg::BIT_CNT_FULL) & resp_word[bit_cnt[3:0]];
            spi_miso_oe_o <= 1'b1;
        end
    end

    // Device side: frame end seen through synchronised chip select
    logic csn_s1;
    logic csn_s2;
    logic csn_d;
    logic ok_s1;
    logic ok_s2;
    logic [7:0] wake_s1;
    logic [7:0] wake_s2;

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            csn_s1 <= 1'b1;
            csn_s2 <= 1'b1;
            csn_d <= 1'b1;
            ok_s1 <= 1'b0;
            ok_s2 <= 1'b0;
            wake_s1 <= 8'h00;
            wake_s2 <= 8'h00;
        end
        else
        begin
            csn_s1 <= spi_csn_i;
            csn_s2 <= csn_s1;
            csn_d <= csn_s2;
            ok_s1 <= frame_ok;
            ok_s2 <= ok_s1;
            wake_s1 <= wake_level_i;
            wake_s2 <= wake_s1;
        end
    end

    // Frame word is quiet while chip select is high
    logic commit;
    logic cmd_wr;
    logic [6:0] cmd_addr;
    logic [7:0] cmd_data;
    logic wake_hit;
    logic ident_hit;
    logic [srma_pkg::CTRL_N-1:0] ctrl_hit;
    logic [srma_pkg::STAT_N-1:0] stat_hit;
    logic any_hit;

    assign commit = csn_s2 & ~csn_d & ok_s2;
    assign cmd_addr = frame_word[6:0];
    assign cmd_wr = frame_word[srma_pkg::MODE_BIT];
    assign cmd_data = frame_word[15:srma_pkg::DATA_LSB];
    assign wake_hit = (cmd_addr == srma_pkg::WAKE_ADDR);
    assign ident_hit = (cmd_addr == srma_pkg::IDENT_ADDR);
    assign any_hit = (|ctrl_hit) | (|stat_hit) | wake_hit | ident_hit;

    srma_pkg::srma_ctrl_t ctrl_q;
    srma_pkg::srma_ctrl_t next_ctrl;
    srma_pkg::srma_stat_t stat_q;
    srma_pkg::srma_stat_t next_stat;

    for (genvar i = 0; i < srma_pkg::CTRL_N; i++)
    begin : g_ctrl
        logic wr;
        logic [7:0] base;
        logic [7:0] hwm;
        assign ctrl_hit[i] = (cmd_addr == srma_pkg::CTRL_ADDR[i]);
        assign wr = commit & cmd_wr & ctrl_hit[i];
        assign hwm = srma_pkg::CTRL_HWMASK[i] & srma_pkg::CTRL_MASK[i];
        assign base = restart_i ?
            (ctrl_q[i] & srma_pkg::CTRL_KEEP[i]) |
            (srma_pkg::CTRL_RESTART[i] & ~srma_pkg::CTRL_KEEP[i]) :
            wr ? (cmd_data & srma_pkg::CTRL_MASK[i]) : ctrl_q[i];
        assign next_ctrl[i] = soft_reset_i ? POR_VAL[i] :
            ctrl_hw_we_i[i] ? (base & ~hwm) | (ctrl_hw_data_i[i] & hwm) : base;
    end

    for (genvar j = 0; j < srma_pkg::STAT_N; j++)
    begin : g_stat
        logic [7:0] clr;
        assign stat_hit[j] = (cmd_addr == srma_pkg::STAT_ADDR[j]);
        assign clr = (commit & cmd_wr & stat_hit[j]) ? srma_pkg::STAT_MASK[j] : 8'h00;
        // Set wins over clear in the same cycle
        assign next_stat[j] = soft_reset_i ? srma_pkg::STAT_POR[j] :
            (stat_q[j] & ~clr) | (status_set_i[j] & srma_pkg::STAT_MASK[j]);
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= POR_VAL;
            stat_q <= srma_pkg::STAT_POR;
        end
        else
        begin
            ctrl_q <= next_ctrl;
            stat_q <= next_stat;
        end
    end

    // Read mux; reserved bits never stored
    logic [7:0] rd_data;
    always_comb
    begin
        rd_data = 8'h00;
        for (int i = 0; i < srma_pkg::CTRL_N; i++)
            if (ctrl_hit[i])
                rd_data = rd_data | ctrl_q[i];
        for (int j = 0; j < srma_pkg::STAT_N; j++)
            if (stat_hit[j])
                rd_data = rd_data | stat_q[j];
        if (wake_hit)
            rd_data = rd_data | (wake_s2 & srma_pkg::WAKE_MASK);
        if (ident_hit)
            rd_data = rd_data | FAMILY_PRODUCT_ID;
    end

    // Answer holds the value before this frame's write
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            resp_word <= srma_pkg::RESP_POR;
            access_done_o <= 1'b0;
        end
        else
        begin
            if (commit)
                resp_word <= {rd_data, frame_word[7:0]};
            access_done_o <= commit;
        end
    end

    assign ctrl_o = ctrl_q;
    assign status_o = stat_q;

    default clocking cb_m @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    logic quiet;
    assign quiet = ~restart_i & ~soft_reset_i & ~(|ctrl_hw_we_i);

    property p_por_load;
        soft_reset_i |=> ctrl_q == POR_VAL && stat_q == srma_pkg::STAT_POR;
    endproperty
    a_por_load: assert property (p_por_load)
        else $error("soft reset did not load defaults");

    property p_restart;
        restart_i && !soft_reset_i && !ctrl_hw_we_i[0] |=>
            ctrl_q[0] == (($past(ctrl_q[0]) & srma_pkg::CTRL_KEEP[0]) |
            (srma_pkg::CTRL_RESTART[0] & ~srma_pkg::CTRL_KEEP[0]));
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart value wrong");

    property p_read_only;
        commit && !cmd_wr && quiet |=> $stable(ctrl_q);
    endproperty
    a_read_only: assert property (p_read_only)
        else $error("read changed a control register");

    property p_write;
        commit && cmd_wr && ctrl_hit[srma_pkg::HW_IDX] && quiet |=>
            ctrl_q[srma_pkg::HW_IDX] ==
            ($past(cmd_data) & srma_pkg::CTRL_MASK[srma_pkg::HW_IDX]);
    endproperty
    a_write: assert property (p_write)
        else $error("write not stored");

    property p_reserved;
        (ctrl_q[srma_pkg::HW_IDX] & ~srma_pkg::CTRL_MASK[srma_pkg::HW_IDX]) == 8'h00 &&
        (stat_q[0] & ~srma_pkg::STAT_MASK[0]) == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bit set");

    property p_hold;
        !commit && quiet |=> $stable(ctrl_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("control changed without cause");

    property p_clear;
        commit && cmd_wr && stat_hit[0] && status_set_i[0] == 8'h00 && !soft_reset_i
            |=> stat_q[0] == 8'h00;
    endproperty
    a_clear: assert property (p_clear)
        else $error("status not cleared");

    property p_set_wins;
        status_set_i[0][0] && !soft_reset_i |=> stat_q[0][0];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("status event lost");

    property p_level;
        commit && wake_hit && !soft_reset_i |=>
            resp_word[15:8] == ($past(wake_s2) & srma_pkg::WAKE_MASK) &&
            ($past(stat_q) & ~stat_q) == '0;
    endproperty
    a_level: assert property (p_level)
        else $error("level answer wrong");

    property p_old_value;
        commit && ctrl_hit[srma_pkg::MSC_IDX] |=>
            resp_word == {$past(ctrl_q[srma_pkg::MSC_IDX]), $past(frame_word[7:0])};
    endproperty
    a_old_value: assert property (p_old_value)
        else $error("answer not the previous value");

    property p_unmapped;
        commit && !any_hit && quiet && status_set_i == '0 |=>
            resp_word[15:8] == 8'h00 && $stable(ctrl_q) && $stable(stat_q);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access had effect");

    property p_stat_read;
        commit && !cmd_wr && status_set_i == '0 && !soft_reset_i |=> $stable(stat_q);
    endproperty
    a_stat_read: assert property (p_stat_read)
        else $error("status read changed status");

    property p_ident;
        commit && ident_hit |=> resp_word[15:8] == FAMILY_PRODUCT_ID;
    endproperty
    a_ident: assert property (p_ident)
        else $error("ident answer wrong");

    property p_hw_overlay;
        ctrl_hw_we_i[srma_pkg::MSC_IDX] && !soft_reset_i |=>
            (ctrl_q[srma_pkg::MSC_IDX] & srma_pkg::CTRL_HWMASK[srma_pkg::MSC_IDX]) ==
            ($past(ctrl_hw_data_i[srma_pkg::MSC_IDX]) &
            srma_pkg::CTRL_HWMASK[srma_pkg::MSC_IDX]);
    endproperty
    a_hw_overlay: assert property (p_hw_overlay)
        else $error("hardware update lost");

    property p_done;
        commit |=> access_done_o;
    endproperty
    a_done: assert property (p_done)
        else $error("committed frame not flagged");

    property p_miso_idle;
        spi_csn_i |-> !spi_miso_oe_o && !spi_miso_o;
    endproperty
    a_miso_idle: assert property (p_miso_idle)
        else $error("data out driven between frames");

    // Consequent lands in the next frame, so chip select must not cancel it
    property p_frame_full;
        @(negedge spi_sclk_i) disable iff (rst_i)
        bit_cnt == srma_pkg::BIT_CNT_LAST |=> frame_ok;
    endproperty
    a_frame_full: assert property (p_frame_full)
        else $error("full frame not flagged");

    property p_frame_long;
        @(negedge spi_sclk_i) disable iff (rst_i)
        bit_cnt == srma_pkg::BIT_CNT_FULL |=> !frame_ok;
    endproperty
    a_frame_long: assert property (p_frame_long)
        else $error("overlong frame accepted");

    c_ctrl_write: cover property (commit && cmd_wr && |ctrl_hit);
    c_stat_clear: cover property (commit && cmd_wr && |stat_hit);
    c_unmapped: cover property (commit && !any_hit);
    c_restart: cover property (restart_i ##1 commit);

endmodule
`default_nettype wire

// File: srma_host_model.sv
// Host SPI master model that sends one frame at a time
`timescale 1ns/1ps
`default_nettype none
module srma_host_model (
    // SPI link
    output logic sclk_o,
    output logic csn_o,
    output logic mosi_o,
    input wire logic miso_i,
    input wire logic miso_oe_i
);
    realtime half = 62.5;
    initial
    begin
        sclk_o = 1'b0;
        csn_o = 1'b1;
        mosi_o = 1'b0;
    end
    // Shifts nbits of w out, returns what came back on miso
    // Edges past the sixteenth wrap round to the start of the word
    task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] r);
        r = 16'hXXXX;
        csn_o = 1'b0;
        #(half);
        // LSB first: address, mode bit, then data byte
        for (int k = 0; k < nbits; k++)
        begin
            sclk_o = 1'b1;
            mosi_o = w[k[3:0]];
            #(half);
            sclk_o = 1'b0;
            r[k[3:0]] = miso_oe_i ? miso_i : 1'bx;
            #(half);
        end
        csn_o = 1'b1;
        // Released line must not keep its last value
        mosi_o = ~mosi_o;
    endtask
endmodule
`default_nettype wire

// File: spi_register_map_access_tb_top.sv
// Testbench for the SPI register bank
`timescale 1ns/1ps
`default_nettype none
module spi_register_map_access_tb_top;
    // Arbitrary identifier value
    localparam logic [7:0] IDENT = 8'h3C;
    localparam logic [7:0] STRAP = 8'hFF;
    localparam logic [7:0] LEVELS = 8'h5A;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sclk, csn, mosi, miso, miso_oe, done;
    logic soft_reset_i = 1'b0;
    logic restart_i = 1'b0;
    logic [srma_pkg::CTRL_N-1:0] hw_we = '0;
    srma_pkg::srma_ctrl_t hw_data = '0;
    srma_pkg::srma_stat_t stat_set = '0;
    srma_pkg::srma_ctrl_t ctrl, exp_ctrl;
    srma_pkg::srma_stat_t stat, exp_stat;
    int n_errors = 0;
    int checks_done = 0;
    int n_done = 0;
    logic [7:0] pend_val, pend_cmd;
    logic pend_ok = 1'b0;
    logic [15:0] resp;
    logic [7:0] wake_lv = LEVELS;

    always #20 mclk_i = ~mclk_i;
    always @(posedge mclk_i) if (done === 1'b1) n_done <= n_done + 1;

    srma_spi_regs #(.FAMILY_PRODUCT_ID(IDENT), .HARDWARE_CONFIG_CONTROL_POR_Y(STRAP)) dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .spi_sclk_i(sclk), .spi_csn_i(csn),
        .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
        .soft_reset_i(soft_reset_i), .restart_i(restart_i), .ctrl_hw_we_i(hw_we),
        .ctrl_hw_data_i(hw_data), .status_set_i(stat_set), .wake_level_i(wake_lv),
        .ctrl_o(ctrl), .status_o(stat), .access_done_o(done));

    srma_host_model host (.sclk_o(sclk), .csn_o(csn), .mosi_o(mosi), .miso_i(miso),
        .miso_oe_i(miso_oe));

    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input string what, input logic [159:0] seen, input logic [159:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick();
        @(posedge mclk_i);
        #1;
    endtask

    // One frame; what it reads is checked in the next frame
    task automatic acc(input logic [6:0] a, input logic w, input logic [7:0] d,
        input logic [7:0] e);
        int n;
        host.xfer({d, w, a}, 16, resp);
        n = 0;
        while (done !== 1'b1 && n < 20)
        begin
            tick();
            n++;
        end
        check("commit", done, 1'b1);
        if (pend_ok)
        begin
            check("read data", resp[15:8], pend_val);
            check("echo", resp[7:0], pend_cmd);
        end
        pend_ok = 1'b1;
        pend_val = e;
        pend_cmd = {w, a};
        repeat (6) tick();
    endtask

    task automatic ctrl_sweep(input logic w, input logic [7:0] d);
        for (int i = 0; i < srma_pkg::CTRL_N; i++)
        begin
            // Reserved positions are always sent as zero
            acc(srma_pkg::CTRL_ADDR[i], w, d & srma_pkg::CTRL_MASK[i], exp_ctrl[i]);
            if (w)
                exp_ctrl[i] = d & srma_pkg::CTRL_MASK[i];
        end
        check("ctrl_o", ctrl, exp_ctrl);
    endtask

    task automatic stat_sweep(input logic w);
        for (int i = 0; i < srma_pkg::STAT_N; i++)
        begin
            acc(srma_pkg::STAT_ADDR[i], w, 8'h00, exp_stat[i]);
            if (w)
                exp_stat[i] = 8'h00;
        end
        check("status_o", stat, exp_stat);
    endtask

    task automatic por_values();
        exp_ctrl = srma_pkg::CTRL_POR;
        exp_ctrl[srma_pkg::HW_IDX] = STRAP & srma_pkg::HARDWARE_CONFIG_CONTROL_Y_MASK;
        exp_stat = srma_pkg::STAT_POR;
    endtask

    initial
    begin
        int n;
        por_values();
        repeat (20) tick();
        rst_i = 1'b0;
        repeat (4) tick();
        ctrl_sweep(1'b0, 8'h00);
        stat_sweep(1'b0);
        acc(srma_pkg::WAKE_ADDR, 1'b1, 8'h00, LEVELS & srma_pkg::WAKE_MASK);
        acc(srma_pkg::IDENT_ADDR, 1'b1, 8'h00, IDENT);
        acc(7'h00, 1'b1, 8'hFF, 8'h00);
        acc(7'h3F, 1'b0, 8'h00, 8'h00);
        acc(srma_pkg::IDENT_ADDR, 1'b0, 8'h00, IDENT);
        wake_lv = 8'hC3;
        acc(srma_pkg::WAKE_ADDR, 1'b0, 8'h00, 8'hC3 & srma_pkg::WAKE_MASK);
        check("ctrl_o", ctrl, exp_ctrl);
        ctrl_sweep(1'b1, 8'hFF);
        ctrl_sweep(1'b0, 8'h00);
        acc(srma_pkg::CTRL_ADDR[5], 1'b1, 8'h00, exp_ctrl[5]);
        exp_ctrl[5] = 8'h00;
        check("ctrl_o", ctrl, exp_ctrl);
        // Frame one bit short must be dropped
        n = n_done;
        host.xfer(16'h0081, 15, resp);
        repeat (12) tick();
        check("refused", n_done, n);
        check("ctrl_o", ctrl, exp_ctrl);
        // Frame one bit long must be dropped as well
        host.xfer(16'h0081, 17, resp);
        repeat (12) tick();
        check("overlong", n_done, n);
        check("ctrl_o", ctrl, exp_ctrl);
        stat_set = {srma_pkg::STAT_N{8'hFF}};
        tick();
        stat_set = '0;
        exp_stat = srma_pkg::STAT_MASK;
        stat_sweep(1'b0);
        stat_sweep(1'b1);
        stat_sweep(1'b0);
        hw_we = '1;
        hw_data = {srma_pkg::CTRL_N{8'h0F}};
        tick();
        hw_we = '0;
        for (int i = 0; i < srma_pkg::CTRL_N; i++)
            exp_ctrl[i] = (exp_ctrl[i] & ~srma_pkg::CTRL_HWMASK[i])
                | (8'h0F & srma_pkg::CTRL_HWMASK[i]);
        check("ctrl_o", ctrl, exp_ctrl);
        restart_i = 1'b1;
        tick();
        restart_i = 1'b0;
        for (int i = 0; i < srma_pkg::CTRL_N; i++)
            exp_ctrl[i] = (exp_ctrl[i] & srma_pkg::CTRL_KEEP[i])
                | (srma_pkg::CTRL_RESTART[i] & ~srma_pkg::CTRL_KEEP[i]);
        check("ctrl_o", ctrl, exp_ctrl);
        ctrl_sweep(1'b0, 8'h00);
        acc(7'h7D, 1'b0, 8'h00, 8'h00);
        soft_reset_i = 1'b1;
        tick();
        soft_reset_i = 1'b0;
        por_values();
        check("ctrl_o", ctrl, exp_ctrl);
        check("status_o", stat, exp_stat);
        ctrl_sweep(1'b0, 8'h00);
        acc(7'h00, 1'b0, 8'h00, 8'h00);
        acc(srma_pkg::IDENT_ADDR, 1'b0, 8'h00, IDENT);
        finish_test();
    end

    initial
    begin
        #1_000_000;
        n_errors++;
        finish_test();
    end
endmodule
`default_nettype wire
